// ---- hdl/smsq_params.svh ----
`ifndef SMSQ_PARAMS_SVH
`define SMSQ_PARAMS_SVH

// Electrical angle held in 22.5 degree units, 16 positions per turn
`define SMSQ_ANGLE_W 4
// Initial angle of 45 degrees
`define SMSQ_ANGLE_INIT 4'h2
// Cosine offset, 90 degrees
`define SMSQ_ANGLE_QUARTER_TURN 4'h4
// Step sizes per resolution
`define SMSQ_STEP_FULL 4'h4
`define SMSQ_STEP_HALF 4'h2
`define SMSQ_STEP_QUARTER 4'h1

// Oscillator divider: chopping period is 16 oscillator cycles
`define SMSQ_PHASE_W 4
`define SMSQ_PHASE_LAST 4'hf
// Phase at which slow decay hands over to fast decay
`define SMSQ_SLOW_END 4'hb

// Winding current levels in percent
`define SMSQ_LEVEL_W 7
`define SMSQ_LVL_100 7'h64
`define SMSQ_LVL_92 7'h5c
`define SMSQ_LVL_71 7'h47
`define SMSQ_LVL_38 7'h26
`define SMSQ_LVL_0 7'h00

`endif

// ---- hdl/smsq_pkg.sv ----
`include "smsq_params.svh"

package smsq_pkg;

   // Resolution decoded from the two select inputs
   typedef enum logic [1:0] {
      RES_STANDBY,
      RES_FULL,
      RES_HALF,
      RES_QUARTER
   } smsq_res_e;

   // Bridge regulation modes
   typedef enum logic [1:0] {
      DECAY_HIZ,
      DECAY_CHARGE,
      DECAY_SLOW,
      DECAY_FAST
   } smsq_decay_e;

   // Four bridge switches of one winding, 1 = on
   typedef struct packed {
      logic upper_switch_one;
      logic upper_switch_two;
      logic lower_switch_one;
      logic lower_switch_two;
   } smsq_bridge_s;

   // Current setting of one winding
   typedef struct packed {
      logic negative;
      logic [`SMSQ_LEVEL_W-1:0] magnitude;
   } smsq_level_s;

   // Pin inputs that pass the synchroniser together
   typedef struct packed {
      logic step_pulse;
      logic rotation_direction;
      logic output_enable;
      logic angle_reset;
      logic resolution_select_hi;
      logic resolution_select_lo;
      logic chop_rc_oscillator;
      logic winding_a_trip;
      logic winding_b_trip;
      logic winding_a_zero;
      logic winding_b_zero;
   } smsq_pins_s;

endpackage : smsq_pkg

// ---- hdl/smsq_input_sync.sv ----
`timescale 1ns/1ps

// Three-stage synchroniser; output follows once stages two and three agree
module smsq_input_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out
);

   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;
   logic [W-1:0] stage3_reg;

   // Shift chain; stage one is read only by stage two
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
      end else begin
         stage1_reg <= pin_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // Accept a new level per bit only when the late stages agree
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         level_out <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (stage2_reg[i] == stage3_reg[i]) begin
               level_out[i] <= stage3_reg[i];
            end
         end
      end
   end

endmodule // smsq_input_sync

// ---- hdl/smsq_bridge_chopper.sv ----
`timescale 1ns/1ps
`include "smsq_params.svh"

// Mixed-decay chopper for one winding bridge
module smsq_bridge_chopper (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic drive_on,
   input wire logic chop_tick,
   input wire logic [`SMSQ_PHASE_W-1:0] chop_phase,
   input wire logic ccw,
   input wire smsq_pkg::smsq_level_s level,
   input wire logic over_trip,
   input wire logic zero_seen,
   output smsq_pkg::smsq_bridge_s bridge
);

   smsq_pkg::smsq_decay_e state_reg;
   smsq_pkg::smsq_decay_e state_next;
   logic forward;

   // Switch pattern for a mode and current direction
   function automatic smsq_pkg::smsq_bridge_s bridge_of(
      input smsq_pkg::smsq_decay_e mode, input logic fwd);
      smsq_pkg::smsq_bridge_s b;
      b = '0;
      unique case (mode)
         smsq_pkg::DECAY_HIZ: b = '0;
         // RULE14: forward mode switches
         // RULE15: reverse mode switches
         smsq_pkg::DECAY_CHARGE: b = fwd ? 4'b1001 : 4'b0110;
         smsq_pkg::DECAY_SLOW: b = 4'b0011;
         smsq_pkg::DECAY_FAST: b = fwd ? 4'b0110 : 4'b1001;
      endcase
      return b;
   endfunction

   // RULE6: CW charges OUT+ high
   assign forward = ~(level.negative ^ ccw);

   // RULE16: charge, slow, fast sequencing
   always_comb begin
      state_next = state_reg;
      if (!drive_on || level.magnitude == `SMSQ_LVL_0) begin
         state_next = smsq_pkg::DECAY_HIZ;
      end else if (chop_tick) begin
         state_next = smsq_pkg::DECAY_CHARGE;
      end else begin
         unique case (state_reg)
            smsq_pkg::DECAY_HIZ: state_next = smsq_pkg::DECAY_HIZ;
            smsq_pkg::DECAY_CHARGE: begin
               if (over_trip) begin
                  state_next = smsq_pkg::DECAY_SLOW;
               end
            end
            smsq_pkg::DECAY_SLOW: begin
               if (chop_phase >= `SMSQ_SLOW_END) begin
                  state_next = smsq_pkg::DECAY_FAST;
               end
            end
            // RULE13: zero current goes Hi-Z
            smsq_pkg::DECAY_FAST: begin
               if (zero_seen) begin
                  state_next = smsq_pkg::DECAY_HIZ;
               end
            end
         endcase
      end
   end

   // Mode and switch registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_reg <= smsq_pkg::DECAY_HIZ;
         bridge <= '0;
      end else begin
         state_reg <= state_next;
         bridge <= bridge_of(state_next, forward);
      end
   end

endmodule // smsq_bridge_chopper

// ---- hdl/smsq_sequencer.sv ----
// What this block does
// RULE1: Step rising edge advances angle one step
// RULE2: Step falling edge leaves angle unchanged
// RULE3: Enable high drives bridges, low Hi-Z
// RULE4: Controller keeps enable low during supply switching
// RULE5: CW: A leads B; CCW: B leads A
// RULE6: Charge start polarity: CW OUT+ high, CCW reversed
// RULE7: Both selects low: standby, oscillator off, outputs off
// RULE8: Select decode: 01 full, 10 half, 11 quarter
// RULE9: Controller resets angle when changing resolution
// RULE10: Angle reset high forces initial angle
// RULE11: Reset state 45 degrees, 100% or 71%
// RULE12: Angle reset drives monitor low
// RULE13: Winding current at zero sets bridge Hi-Z
// RULE14: Forward direction charge, slow, fast switch patterns
// RULE15: Reverse direction charge, slow, fast switch patterns
// RULE16: Regulate current using three bridge modes
// RULE17: Chopping timed from internal RC oscillator
// RULE18: Chopping period is oscillator divided by 16
// RULE19: Components set chopping between 50 and 100 kHz
// RULE20: Angle wraps at 360, sine-table current levels
// RULE21: Monitor active-low open drain at 45 degrees
`timescale 1ns/1ps
`include "smsq_params.svh"

// Top of the step sequencer: pins pass the
// synchroniser, the angle is kept here, both
// winding levels are looked up, and one
// chopper per winding sets its bridge
module smsq_sequencer (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic step_pulse,
   input wire logic rotation_direction,
   input wire logic output_enable,
   input wire logic angle_reset,
   input wire logic resolution_select_hi,
   input wire logic resolution_select_lo,
   input wire logic chop_rc_oscillator,
   input wire logic winding_a_trip,
   input wire logic winding_b_trip,
   input wire logic winding_a_zero,
   input wire logic winding_b_zero,
   output smsq_pkg::smsq_bridge_s winding_a_output,
   output smsq_pkg::smsq_bridge_s winding_b_output,
   output smsq_pkg::smsq_level_s winding_a_level,
   output smsq_pkg::smsq_level_s winding_b_level,
   output logic [`SMSQ_ANGLE_W-1:0] angle_position,
   output logic chop_active,
   output logic angle_origin_monitor_out,
   output logic angle_origin_monitor_oe_n
);

   // Pin bundle before and after the sync
   smsq_pkg::smsq_pins_s pins_raw;
   smsq_pkg::smsq_pins_s pins;
   logic [$bits(smsq_pkg::smsq_pins_s)-1:0] pins_level;
   smsq_pkg::smsq_res_e resolution;

   // Edge detection history
   logic step_prev_reg;
   logic osc_prev_reg;
   logic step_rise;
   logic osc_rise;

   // Angle state and its increment
   logic [`SMSQ_ANGLE_W-1:0] angle_reg;
   logic [`SMSQ_ANGLE_W-1:0] angle_next;
   logic [`SMSQ_ANGLE_W-1:0] step_size;

   // Chopping phase and shared controls
   logic [`SMSQ_PHASE_W-1:0] phase_reg;
   logic chop_tick;
   logic drive_on;
   logic ccw;

   // Levels ahead of their registers
   smsq_pkg::smsq_level_s level_a_next;
   smsq_pkg::smsq_level_s level_b_next;

   // Decode the resolution select pair
   // Every code is legal, so no default
   function automatic smsq_pkg::smsq_res_e res_of(input logic sel_hi,
      input logic sel_lo);
      smsq_pkg::smsq_res_e r;
      r = smsq_pkg::RES_STANDBY;
      unique case ({sel_hi, sel_lo})
         2'b00: r = smsq_pkg::RES_STANDBY;
         2'b01: r = smsq_pkg::RES_FULL;
         2'b10: r = smsq_pkg::RES_HALF;
         2'b11: r = smsq_pkg::RES_QUARTER;
      endcase
      return r;
   endfunction

   // Sine of an angle in 22.5 degree units, shaped by resolution
   // Low bits pick the quadrant entry,
   // the top bit gives the sign, and a
   // zero level is never negative
   function automatic smsq_pkg::smsq_level_s level_of(
      input logic [`SMSQ_ANGLE_W-1:0] k, input smsq_pkg::smsq_res_e r);
      smsq_pkg::smsq_level_s l;
      logic [`SMSQ_LEVEL_W-1:0] mag;
      mag = `SMSQ_LVL_0;
      l = '0;
      // Rising quadrant for even quadrants, falling for odd ones
      unique case ({k[2], k[1:0]})
         3'b000: mag = `SMSQ_LVL_0;
         3'b001: mag = `SMSQ_LVL_38;
         3'b010: mag = `SMSQ_LVL_71;
         3'b011: mag = `SMSQ_LVL_92;
         3'b100: mag = `SMSQ_LVL_100;
         3'b101: mag = `SMSQ_LVL_92;
         3'b110: mag = `SMSQ_LVL_71;
         3'b111: mag = `SMSQ_LVL_38;
      endcase
      // Full and half step drive every non-zero winding at 100%
      if (r != smsq_pkg::RES_QUARTER && mag != `SMSQ_LVL_0) begin
         mag = `SMSQ_LVL_100;
      end
      if (r == smsq_pkg::RES_STANDBY) begin
         mag = `SMSQ_LVL_0;
      end
      l.magnitude = mag;
      l.negative = k[3] && (mag != `SMSQ_LVL_0);
      return l;
   endfunction

   // Gather the pin inputs for the synchroniser
   // One bundle keeps all stages aligned
   // so related pins move together
   always_comb begin
      pins_raw.step_pulse = step_pulse;
      pins_raw.rotation_direction = rotation_direction;
      pins_raw.output_enable = output_enable;
      pins_raw.angle_reset = angle_reset;
      pins_raw.resolution_select_hi = resolution_select_hi;
      pins_raw.resolution_select_lo = resolution_select_lo;
      pins_raw.chop_rc_oscillator = chop_rc_oscillator;
      pins_raw.winding_a_trip = winding_a_trip;
      pins_raw.winding_b_trip = winding_b_trip;
      pins_raw.winding_a_zero = winding_a_zero;
      pins_raw.winding_b_zero = winding_b_zero;
   end

   // All pins come from outside the ref_clk domain
   // Four edges of latency: three stages
   // and the agreement flop; short glitches
   // are dropped before the logic sees them
   smsq_input_sync #(
      .W($bits(smsq_pkg::smsq_pins_s))
   ) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin_in(pins_raw),
      .level_out(pins_level)
   );

   assign pins = smsq_pkg::smsq_pins_s'(pins_level);

   // RULE8: resolution decode
   assign resolution = res_of(pins.resolution_select_hi,
      pins.resolution_select_lo);

   // Low direction level is counter-clockwise
   // and flips count direction and polarity
   assign ccw = ~pins.rotation_direction;

   // RULE3: enable gates both bridges
   // RULE7: standby turns bridges off
   // Shared by both choppers, so the two
   // bridges switch off on the same edge
   assign drive_on = pins.output_enable &&
      (resolution != smsq_pkg::RES_STANDBY);

   // Edge history of the step and oscillator levels
   // Reset to the idle low level, so no
   // false edge follows reset
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         step_prev_reg <= 1'b0;
         osc_prev_reg <= 1'b0;
      end else begin
         step_prev_reg <= pins.step_pulse;
         osc_prev_reg <= pins.chop_rc_oscillator;
      end
   end

   // RULE1: rising step edge only
   // RULE2: falling edge ignored
   assign step_rise = pins.step_pulse && !step_prev_reg;

   // RULE17: chopping follows the RC oscillator
   assign osc_rise = pins.chop_rc_oscillator && !osc_prev_reg;

   // Tick starts each chopping period
   // and restarts both chopper cycles
   // RULE18: divide oscillator by 16
   assign chop_tick = osc_rise && (phase_reg == `SMSQ_PHASE_LAST);

   // Chopping phase counter, frozen at zero in standby
   // Leaving standby restarts a full period
   // so the first charge is never short
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         phase_reg <= '0;
      end else if (resolution == smsq_pkg::RES_STANDBY) begin
         // RULE7: oscillator disabled
         phase_reg <= '0;
      end else if (osc_rise) begin
         phase_reg <= phase_reg + 1'b1;
      end
   end

   // Step size of the selected resolution
   // Standby steps by zero: steps are lost,
   // the angle is kept
   always_comb begin
      step_size = '0;
      unique case (resolution)
         smsq_pkg::RES_STANDBY: step_size = '0;
         smsq_pkg::RES_FULL: step_size = `SMSQ_STEP_FULL;
         smsq_pkg::RES_HALF: step_size = `SMSQ_STEP_HALF;
         smsq_pkg::RES_QUARTER: step_size = `SMSQ_STEP_QUARTER;
      endcase
   end

   // Next electrical angle
   // Angle reset wins over a step edge in
   // the same cycle; the four-bit sum wraps
   // on its own, which gives modulo 360
   always_comb begin
      angle_next = angle_reg;
      if (pins.angle_reset) begin
         // RULE10: hold initial angle
         // RULE11: initial angle 45 degrees
         angle_next = `SMSQ_ANGLE_INIT;
      end else if (step_rise) begin
         // RULE20: angle wraps modulo 360
         // RULE5: CW counts up, CCW down
         if (ccw) begin
            angle_next = angle_reg - step_size;
         end else begin
            angle_next = angle_reg + step_size;
         end
      end
   end

   // Electrical angle register
   // Reset value is the origin angle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         angle_reg <= `SMSQ_ANGLE_INIT;
      end else begin
         angle_reg <= angle_next;
      end
   end

   // Looked up from the next angle so levels
   // change on the same edge as the angle
   // RULE5: A follows cosine, B sine
   // RULE20: sine-derived current table
   // RULE11: 100% or 71% at reset
   assign level_a_next = level_of(
      angle_next + `SMSQ_ANGLE_QUARTER_TURN, resolution);
   assign level_b_next = level_of(angle_next, resolution);

   // Winding current settings and status outputs
   // Levels read zero during reset, so the
   // choppers hold their bridges off
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         winding_a_level <= '0;
         winding_b_level <= '0;
         angle_position <= `SMSQ_ANGLE_INIT;
         chop_active <= 1'b0;
      end else begin
         winding_a_level <= level_a_next;
         winding_b_level <= level_b_next;
         angle_position <= angle_next;
         chop_active <= drive_on;
      end
   end

   // Open-drain monitor: output held low, enable decides the level
   // With the enable high the pull-up
   // sets the pin level, never the block
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         angle_origin_monitor_out <= 1'b0;
         angle_origin_monitor_oe_n <= 1'b1;
      end else begin
         angle_origin_monitor_out <= 1'b0;
         // RULE12: low during angle reset
         // RULE21: low at initial angle
         angle_origin_monitor_oe_n <= !(pins.angle_reset ||
            angle_next == `SMSQ_ANGLE_INIT);
      end
   end

   // Winding A bridge chopper
   // Each chopper owns its own trip and
   // zero comparator inputs
   smsq_bridge_chopper u_chop_a (
      .ref_clk(ref_clk),
      .reset(reset),
      .drive_on(drive_on),
      .chop_tick(chop_tick),
      .chop_phase(phase_reg),
      .ccw(ccw),
      .level(winding_a_level),
      .over_trip(pins.winding_a_trip),
      .zero_seen(pins.winding_a_zero),
      .bridge(winding_a_output)
   );

   // Winding B bridge chopper
   // Same tick and phase as winding A keep
   // both windings on one chopping period
   smsq_bridge_chopper u_chop_b (
      .ref_clk(ref_clk),
      .reset(reset),
      .drive_on(drive_on),
      .chop_tick(chop_tick),
      .chop_phase(phase_reg),
      .ccw(ccw),
      .level(winding_b_level),
      .over_trip(pins.winding_b_trip),
      .zero_seen(pins.winding_b_zero),
      .bridge(winding_b_output)
   );

endmodule // smsq_sequencer

// ---- dv/smsq_sequencer_properties.sv ----
`timescale 1ns/1ps
`include "smsq_params.svh"

// Port-level properties of the step sequencer
module smsq_seq_props (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic output_enable,
   input wire logic angle_reset,
   input wire logic resolution_select_hi,
   input wire logic resolution_select_lo,
   input wire logic chop_rc_oscillator,
   input wire smsq_pkg::smsq_bridge_s winding_a_output,
   input wire smsq_pkg::smsq_bridge_s winding_b_output,
   input wire smsq_pkg::smsq_level_s winding_a_level,
   input wire smsq_pkg::smsq_level_s winding_b_level,
   input wire logic [`SMSQ_ANGLE_W-1:0] angle_position,
   input wire logic chop_active,
   input wire logic angle_origin_monitor_out,
   input wire logic angle_origin_monitor_oe_n
);
   logic [3:0] prev_a_reg;
   logic [3:0] rises_reg;
   logic osc_reg;
   logic armed_reg;
   logic entry;

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   // Winding A leaves Hi-Z into charge
   assign entry = prev_a_reg == 4'h0 && winding_a_output != 4'h0;

   // Oscillator rises counted between charge entries
   always_ff @(posedge ref_clk) begin
      prev_a_reg <= winding_a_output;
      osc_reg <= chop_rc_oscillator;
      if (entry) begin
         rises_reg <= 4'h0;
      end else if (chop_rc_oscillator && !osc_reg) begin
         rises_reg <= rises_reg + 4'h1;
      end
      armed_reg <= !reset && chop_active && (armed_reg || entry);
   end

   a_bridge_legal: assert property (
      winding_a_output inside {4'h0, 4'h3, 4'h6, 4'h9}
      && winding_b_output inside {4'h0, 4'h3, 4'h6, 4'h9})
      else $error("bridge pattern outside the three modes");
   a_enable_off: assert property (
      !output_enable [*8] |-> !chop_active
      && winding_a_output == 4'h0 && winding_b_output == 4'h0)
      else $error("bridges driven while disabled");
   a_standby_off: assert property (
      (!resolution_select_hi && !resolution_select_lo) [*8] |-> !chop_active
      && winding_a_level.magnitude == 7'h00 && winding_b_output == 4'h0)
      else $error("standby not honoured");
   a_reset_origin: assert property (
      angle_reset [*8] |-> angle_position == `SMSQ_ANGLE_INIT
      && !angle_origin_monitor_oe_n)
      else $error("angle reset not forcing origin");
   a_reset_level: assert property (
      (angle_reset && $stable({resolution_select_hi, resolution_select_lo}))
      [*8] ##0 resolution_select_hi |-> winding_b_level.magnitude ==
      (resolution_select_lo ? `SMSQ_LVL_71 : `SMSQ_LVL_100))
      else $error("origin level wrong");
   a_monitor_off: assert property (
      angle_position != `SMSQ_ANGLE_INIT |-> angle_origin_monitor_oe_n
      && !angle_origin_monitor_out)
      else $error("monitor asserted away from origin");
   a_step_gap: assert property (
      $changed(angle_position) |=> $stable(angle_position) [*3])
      else $error("angle moved twice in quick succession");
   a_chop_period: assert property (
      entry && armed_reg |-> rises_reg == 4'h0)
      else $error("charge start off the 16-cycle boundary");
endmodule // smsq_seq_props

bind smsq_sequencer smsq_seq_props smsq_seq_props_inst (
   .ref_clk, .reset, .output_enable, .angle_reset, .resolution_select_hi,
   .resolution_select_lo, .chop_rc_oscillator, .winding_a_output,
   .winding_b_output, .winding_a_level, .winding_b_level, .angle_position,
   .chop_active, .angle_origin_monitor_out, .angle_origin_monitor_oe_n
);

// ---- dv/smsq_host_model.sv ----
`timescale 1ns/1ps

// Controller and motor stand-in: step pin, oscillator, current sense
module smsq_host_model (
   input wire logic ref_clk,
   input wire smsq_pkg::smsq_bridge_s winding_a_output,
   input wire smsq_pkg::smsq_bridge_s winding_b_output,
   output logic step_pulse,
   output logic chop_rc_oscillator,
   output logic winding_a_trip,
   output logic winding_b_trip,
   output logic winding_a_zero,
   output logic winding_b_zero
);
   logic [3:0] br [2];
   logic [5:0] cnt [2] = '{6'h0, 6'h0};
   logic decaying [2] = '{1'b0, 1'b0};

   // 1 MHz oscillator gives 62.5 kHz chopping
   initial begin
      step_pulse = 1'b0;
      chop_rc_oscillator = 1'b0;
      #7;
      forever #500 chop_rc_oscillator = ~chop_rc_oscillator;
   end

   // Step pin level held 8 cycles, above the minimum of 4
   task automatic edge_to(input logic level);
      step_pulse = level;
      repeat (8) @(negedge ref_clk);
   endtask

   // Comparators: trip late in charge, zero late in fast decay
   assign br[0] = winding_a_output;
   assign br[1] = winding_b_output;
   assign winding_a_trip = !decaying[0] && cnt[0] > 6'h13;
   assign winding_b_trip = !decaying[1] && cnt[1] > 6'h13;
   assign winding_a_zero = decaying[0] && cnt[0] > 6'h13;
   assign winding_b_zero = decaying[1] && cnt[1] > 6'h13;

   // Current ramps while driven; slow decay marks the falling half
   always @(negedge ref_clk) begin
      for (int i = 0; i < 2; i++) begin
         if (br[i] == 4'h3) decaying[i] <= 1'b1;
         else if (br[i] == 4'h0) decaying[i] <= 1'b0;
         if (br[i] == 4'h9 || br[i] == 4'h6) cnt[i] <= cnt[i] + 6'h1;
         else cnt[i] <= 6'h0;
      end
   end
endmodule // smsq_host_model

// ---- dv/smsq_sequencer_test.sv ----
`timescale 1ns/1ps
`include "smsq_params.svh"

// Self-checking bench for the step sequencer
module smsq_sequencer_test;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic rotation_direction = 1'b1;
   logic output_enable = 1'b0;
   logic angle_reset = 1'b1;
   logic resolution_select_hi = 1'b0;
   logic resolution_select_lo = 1'b1;
   logic step_pulse, chop_rc_oscillator, winding_a_trip, winding_b_trip;
   logic winding_a_zero, winding_b_zero, chop_active;
   logic angle_origin_monitor_out, angle_origin_monitor_oe_n;
   smsq_pkg::smsq_bridge_s winding_a_output, winding_b_output;
   smsq_pkg::smsq_level_s winding_a_level, winding_b_level;
   logic [`SMSQ_ANGLE_W-1:0] angle_position;
   int fails = 0;
   int checked = 0;

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;

   smsq_sequencer smsq_sequencer_inst (
      .ref_clk, .reset, .step_pulse, .rotation_direction, .output_enable,
      .angle_reset, .resolution_select_hi, .resolution_select_lo,
      .chop_rc_oscillator, .winding_a_trip, .winding_b_trip,
      .winding_a_zero, .winding_b_zero, .winding_a_output,
      .winding_b_output, .winding_a_level, .winding_b_level,
      .angle_position, .chop_active, .angle_origin_monitor_out,
      .angle_origin_monitor_oe_n
   );

   smsq_host_model smsq_host_model_inst (
      .ref_clk, .winding_a_output, .winding_b_output, .step_pulse,
      .chop_rc_oscillator, .winding_a_trip, .winding_b_trip,
      .winding_a_zero, .winding_b_zero
   );

   task automatic check(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("checked %0d failed %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Resolution change under angle reset, optionally released
   task automatic set_mode(input logic hi, input logic lo, input logic hold);
      angle_reset = 1'b1;
      resolution_select_hi = hi;
      resolution_select_lo = lo;
      wait_clk(10);
      angle_reset = hold;
      wait_clk(8);
   endtask

   // Bridges must stay off for n cycles
   task automatic quiet(input int n);
      logic [7:0] seen;
      seen = 8'h00;
      for (int t = 0; t < n; t++) begin
         wait_clk(1);
         seen = seen | {winding_a_output, winding_b_output};
      end
      check("bridges_off", 8'h00, seen);
   endtask

   // One step: rising edge moves, falling edge does not
   task automatic step_check(input logic [3:0] ang, input logic [7:0] la,
      input logic [7:0] lb);
      smsq_host_model_inst.edge_to(1'b1);
      check("angle", {4'h0, ang}, {4'h0, angle_position});
      check("level_a", la, winding_a_level);
      check("level_b", lb, winding_b_level);
      check("monitor", {7'h0, ang != 4'h2},
         {7'h0, angle_origin_monitor_oe_n});
      smsq_host_model_inst.edge_to(1'b0);
      check("angle_fall", {4'h0, ang}, {4'h0, angle_position});
   endtask

   // Bridge A walks Hi-Z, charge, slow, fast, Hi-Z
   task automatic walk(input logic [3:0] chg, input logic [3:0] fst);
      logic [3:0] seen [5];
      logic [3:0] last;
      int n;
      last = 4'hf;
      n = 0;
      for (int t = 0; t < 2000 && n < 5; t++) begin
         wait_clk(1);
         if (winding_a_output !== last
            && (n > 0 || winding_a_output === 4'h0)) begin
            seen[n] = winding_a_output;
            n++;
         end
         last = winding_a_output;
      end
      check("charge", {4'h0, chg}, {4'h0, seen[1]});
      check("slow", 8'h03, {4'h0, seen[2]});
      check("fast", {4'h0, fst}, {4'h0, seen[3]});
      check("zero_hiz", 8'h00, {4'h0, seen[4]});
   endtask

   // Origin state held by angle reset in full, half and quarter step
   task automatic t_origin();
      logic [7:0] want;
      for (int r = 1; r < 4; r++) begin
         set_mode(r[1], r[0], 1'b1);
         want = (r == 3) ? {1'b0, `SMSQ_LVL_71} : {1'b0, `SMSQ_LVL_100};
         check("angle", 8'h02, {4'h0, angle_position});
         check("level_a", want, winding_a_level);
         check("level_b", want, winding_b_level);
         check("monitor", 8'h00, {7'h0, angle_origin_monitor_oe_n});
      end
   endtask

   // Full steps both ways with wrap, then half and quarter
   task automatic t_steps();
      set_mode(1'b0, 1'b1, 1'b0);
      step_check(4'h6, 8'he4, 8'h64);
      step_check(4'ha, 8'he4, 8'he4);
      step_check(4'he, 8'h64, 8'he4);
      step_check(4'h2, 8'h64, 8'h64);
      rotation_direction = 1'b0;
      wait_clk(8);
      step_check(4'he, 8'h64, 8'he4);
      set_mode(1'b1, 1'b0, 1'b0);
      step_check(4'h0, 8'h64, 8'h00);
      rotation_direction = 1'b1;
      set_mode(1'b1, 1'b1, 1'b0);
      step_check(4'h3, 8'h26, 8'h5c);
   endtask

   // Bridge sequence in both directions at the origin
   task automatic t_chop();
      set_mode(1'b0, 1'b1, 1'b0);
      walk(4'h9, 4'h6);
      rotation_direction = 1'b0;
      walk(4'h6, 4'h9);
      rotation_direction = 1'b1;
   endtask

   // Disabled bridges stay off, then resume
   task automatic t_enable();
      output_enable = 1'b0;
      wait_clk(8);
      check("chop_off", 8'h00, {7'h0, chop_active});
      quiet(500);
      output_enable = 1'b1;
      wait_clk(8);
      check("chop_on", 8'h01, {7'h0, chop_active});
   endtask

   // Standby ignores steps and keeps bridges off
   task automatic t_standby();
      set_mode(1'b0, 1'b0, 1'b0);
      check("chop_off", 8'h00, {7'h0, chop_active});
      check("level_a", 8'h00, winding_a_level);
      smsq_host_model_inst.edge_to(1'b1);
      smsq_host_model_inst.edge_to(1'b0);
      check("angle", 8'h02, {4'h0, angle_position});
      quiet(500);
   endtask

   initial begin
      wait_clk(2);
      reset = 1'b0;
      output_enable = 1'b1;
      wait_clk(8);
      t_origin();
      t_steps();
      t_chop();
      t_enable();
      t_standby();
      print_verdict();
   end

   // Watchdog well beyond the expected run
   initial begin
      #2000000;
      fails++;
      print_verdict();
   end
endmodule // smsq_sequencer_test
